/* File: hw/qdr_read_regs.svh */
// Constants of the quad double-rate read link and its controller registers
`ifndef QDR_READ_REGS_SVH
`define QDR_READ_REGS_SVH

// ----------------------------------------------------------------------
// Link codes and counts
// ----------------------------------------------------------------------
`define CMD_QUAD_DOUBLE_RATE_READ 8'hed
`define MODE_CONT_NIBBLE          4'ha
`define DUMMY_DEFAULT             4'h6
`define ARRAY_TOP_ADDR            24'h7fffff
`define CMD_LAST                  4'h7
`define ADDR_LAST                 4'h2

// ----------------------------------------------------------------------
// Controller register offsets
// ----------------------------------------------------------------------
`define OFS_ADDR                  8'h00
`define OFS_CONFIG                8'h04
`define OFS_LENGTH                8'h08
`define OFS_CONTROL               8'h0c
`define OFS_DATA                  8'h10

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CFG_DUMMY_LSB             0
`define CFG_SKIP_BIT              4
`define CFG_MODE_LSB              8
`define CTRL_START_BIT            0
`define STAT_BUSY_BIT             0
`define STAT_READY_BIT            1
`define STAT_OVERRUN_BIT          2
`define STAT_DONE_BIT             3
`define RST_ADDR                  24'h000000
`define RST_DUMMY                 4'h6
`define RST_MODE                  8'hff
`define RST_LENGTH                16'h0001

`endif

/* File: hw/qdr_read_pkg.sv */
// Types and shared helpers of the quad double-rate read link
`include "qdr_read_regs.svh"

package qdr_read_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE   = 3'b000,
        DEV_CMD    = 3'b001,
        DEV_ADDR   = 3'b010,
        DEV_DUMMY  = 3'b011,
        DEV_DATA   = 3'b100,
        DEV_IGNORE = 3'b101
    } dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE  = 3'b000,
        HST_CMD   = 3'b001,
        HST_ADDR  = 3'b010,
        HST_DUMMY = 3'b011,
        HST_DATA  = 3'b100,
        HST_TAIL  = 3'b101
    } host_state_t;

    typedef struct packed {
        dev_state_t  state;
        logic [3:0]  cnt;
        logic [6:0]  cmd_sh;
        logic [3:0]  rise_nib;
        logic [23:0] addr;
        logic [3:0]  lo_hold;
        logic [3:0]  out_rise;
        logic        oe;
    } dev_regs_t;

    typedef struct packed {
        host_state_t state;
        logic [1:0]  ph;
        logic [15:0] cnt;
        logic [23:0] start_addr;
        logic [3:0]  dummy;
        logic        skip;
        logic [7:0]  mode;
        logic [15:0] length;
        logic [3:0]  rise;
        logic [7:0]  data;
        logic        ready;
        logic        overrun;
        logic        done;
        logic        cs_n;
        logic        sck;
        logic [3:0]  io_out;
        logic [3:0]  io_oe;
        logic [31:0] rdata;
    } host_regs_t;

    // Zero setting selects the default length
    function automatic logic [3:0] dummy_clocks(input logic [3:0] setting);
        return (setting == 4'h0) ? `DUMMY_DEFAULT : setting;
    endfunction : dummy_clocks

endpackage : qdr_read_pkg

/* File: hw/spi_quad_if.sv */
// Four-line serial link between host controller and flash end
`timescale 1ns/1ps
`default_nettype none

interface spi_quad_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] host_io_out;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_out;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // Released lines float high as if pulled up
    assign io = (host_io_out & host_io_oe) | (dev_io_out & dev_io_oe)
              | ~(host_io_oe | dev_io_oe);

    modport host (output cs_n, output sck, output host_io_out,
                  output host_io_oe, input io);
    modport device (input cs_n, input sck, input io,
                    output dev_io_out, output dev_io_oe);
endinterface : spi_quad_if

`default_nettype wire

/* File: hw/bit_sync.sv */
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : bit_sync

`default_nettype wire

/* File: hw/qdr_flash_end.sv */
// Flash end of the quad double-rate read, clocked by the link clock
//
// Operation
// - Host sets quad enable before reading
// - Command code taken on io0, one bit/clock
// - 24-bit address, nibble per clock edge
// - Dummy phase, default six clocks, then data
// - Data out on four lines, both edges
// - Address increments per byte, wraps to zero
// - Chip enable high stops output, releases lines
// - Mode nibble A enters command-skipping continuous read
// - Other mode value leaves continuous read
// - Read rejected while write in progress; a skip-mode frame sees the level left from the previous frame
// - Host gives enough dummy clocks for turnaround
// - Host floats low mode nibble if one dummy
// - Dummy length follows the read setting
`timescale 1ns/1ps
`default_nettype none
`include "qdr_read_regs.svh"

module qdr_flash_end (
    // Link
    spi_quad_if.device  link,
    // Power-on reset of the end
    input  wire logic        rst,
    // Chip status and settings, slow levels
    input  wire logic        write_in_progress,
    input  wire logic        quad_lines_enable_bit,
    input  wire logic [3:0]  read_dummy_setting,
    // Array read port, link clock domain
    output logic      [23:0] array_addr,
    input  wire logic [7:0]  array_data,
    // Mode status
    output logic             continuous_read_mode
);
    import qdr_read_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    dev_regs_t   cur;
    dev_regs_t   next;
    dev_state_t  frame_st;
    logic        frame_rst;
    logic        cont;
    logic [3:0]  fall_in;
    logic [3:0]  out_fall;
    logic [5:0]  sync_q;
    logic        wip_s;
    logic        qe_s;
    logic [3:0]  dummy_s;
    logic [7:0]  cmd_word;
    logic [23:0] addr_word;

    // ------------------------------------------------------------------
    // Frame reset
    // ------------------------------------------------------------------
    // The link clock stops between frames, so chip enable high
    // must clear the frame state without any edge.
    assign frame_rst = link.cs_n | rst;

    // ------------------------------------------------------------------
    // Status levels into the link domain
    // ------------------------------------------------------------------
    // Limitation: the first two link clocks of a frame fill the
    // synchroniser; a command frame checks after eight, but a skip-mode frame
    // checks write in progress on its first clock, with the previous frame's level.
    bit_sync #(
        .WIDTH (6)
    ) u_status_sync (
        .clk (link.sck),
        .rst (rst),
        .d   ({write_in_progress, quad_lines_enable_bit,
               read_dummy_setting}),
        .q   (sync_q)
    );

    assign wip_s   = sync_q[5];
    assign qe_s    = sync_q[4];
    assign dummy_s = sync_q[3:0];

    // ------------------------------------------------------------------
    // Next state on the rising link edge
    // ------------------------------------------------------------------
    always_comb begin
        next      = cur;
        frame_st  = cur.state;
        cmd_word  = {cur.cmd_sh, link.io[0]};
        addr_word = {cur.addr[15:0], cur.rise_nib, fall_in};

        // First edge of a frame picks the entry phase
        if (cur.state == DEV_IDLE) begin
            if (!cont)
                frame_st = DEV_CMD;
            else if (wip_s)
                frame_st = DEV_IGNORE;
            else
                frame_st = DEV_ADDR;
        end

        case (frame_st)
            DEV_CMD: begin
                next.state  = DEV_CMD;
                next.cmd_sh = cmd_word[6:0];
                next.cnt    = cur.cnt + 4'h1;
                if (cur.cnt == `CMD_LAST) begin
                    next.cnt = 4'h0;
                    // Unknown code or quad lines off: stay mute
                    if (cmd_word == `CMD_QUAD_DOUBLE_RATE_READ
                        && qe_s && !wip_s)
                        next.state = DEV_ADDR;
                    else
                        next.state = DEV_IGNORE;
                end
            end

            DEV_ADDR: begin
                next.state    = DEV_ADDR;
                next.rise_nib = link.io;
                next.cnt      = cur.cnt + 4'h1;
                // Falling nibble of the previous clock joins here
                if (cur.cnt != 4'h0)
                    next.addr = addr_word;
                if (cur.cnt == `ADDR_LAST) begin
                    next.cnt   = 4'h0;
                    next.state = DEV_DUMMY;
                end
            end

            DEV_DUMMY: begin
                next.state = DEV_DUMMY;
                next.cnt   = cur.cnt + 4'h1;
                if (cur.cnt == 4'h0)
                    next.addr = addr_word;
                if (cur.cnt == dummy_clocks(dummy_s) - 4'h1) begin
                    next.cnt   = 4'h0;
                    next.state = DEV_DATA;
                end
            end

            DEV_DATA: begin
                next.state    = DEV_DATA;
                next.oe       = 1'b1;
                next.out_rise = array_data[7:4];
                next.lo_hold  = array_data[3:0];
                if (cur.addr == `ARRAY_TOP_ADDR)
                    next.addr = 24'h000000;
                else
                    next.addr = cur.addr + 24'h000001;
            end

            DEV_IGNORE: begin
                // Ongoing write is not touched; wait for chip enable
                next.state = DEV_IGNORE;
            end

            default: begin
                next = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Rising edge state
    // ------------------------------------------------------------------
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst)
            cur <= '0;
        else
            cur <= next;
    end

    // ------------------------------------------------------------------
    // Falling edge capture and drive
    // ------------------------------------------------------------------
    // Trade-off: a second edge process instead of a doubled clock,
    // since the end has no clock of its own.
    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            fall_in  <= 4'h0;
            out_fall <= 4'h0;
        end else begin
            fall_in  <= link.io;
            out_fall <= cur.lo_hold;
        end
    end

    // ------------------------------------------------------------------
    // Continuous read mode
    // ------------------------------------------------------------------
    // Survives chip enable high; power-on reset or a mode nibble other than A clears it.
    // Mode nibble is the rising half of the first dummy clock.
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst)
            cont <= 1'b0;
        else if (frame_st == DEV_DUMMY && cur.cnt == 4'h0)
            cont <= (link.io == `MODE_CONT_NIBBLE);
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // High half while the clock is high, low half after its fall
    assign link.dev_io_out    = link.sck ? cur.out_rise : out_fall;
    assign link.dev_io_oe     = {4{cur.oe}};
    assign array_addr         = cur.addr;
    assign continuous_read_mode = cont;

endmodule : qdr_flash_end

`default_nettype wire

/* File: hw/qdr_host_end.sv */
// Host controller end of the quad double-rate read, with its registers
`timescale 1ns/1ps
`default_nettype none
`include "qdr_read_regs.svh"

module qdr_host_end (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Link
    spi_quad_if.host         link
);
    import qdr_read_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    host_regs_t  cur;
    host_regs_t  next;
    logic [1:0]  np;
    logic [3:0]  io_s;
    logic [7:0]  cmd_shift;
    logic [23:0] addr_shift;
    logic [15:0] last_byte;
    logic        sampling;

    bit_sync #(
        .WIDTH (4)
    ) u_io_sync (
        .clk (clk_sys),
        .rst (rst),
        .d   (link.io),
        .q   (io_s)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Link clock is clk_sys over four; data moves mid half-period so
    // it never changes on the edge that samples it.
    always_comb begin
        next       = cur;
        next.rdata = 32'h0;
        np         = cur.ph + 2'h1;
        next.ph    = np;
        cmd_shift  = `CMD_QUAD_DOUBLE_RATE_READ << cur.cnt[2:0];
        addr_shift = cur.start_addr << {cur.cnt[1:0], np[1], 2'b00};
        last_byte  = (cur.length == 16'h0) ? 16'h0 : cur.length - 16'h1;
        sampling   = (cur.state == HST_TAIL)
                   || (cur.state == HST_DATA && cur.cnt != 16'h0);

        if (reg_read) begin
            case (reg_addr)
                `OFS_ADDR:    next.rdata = {8'h0, cur.start_addr};
                `OFS_CONFIG:  next.rdata = {16'h0, cur.mode, 3'h0, cur.skip, cur.dummy};
                `OFS_LENGTH:  next.rdata = {16'h0, cur.length};
                `OFS_CONTROL: begin
                    next.rdata = {28'h0, cur.done, cur.overrun, cur.ready,
                                  cur.state != HST_IDLE};
                    next.done    = 1'b0;
                    next.overrun = 1'b0;
                end
                `OFS_DATA: begin
                    next.rdata = {24'h0, cur.data};
                    next.ready = 1'b0;
                end
                default:      next.rdata = 32'h0;
            endcase
        end

        if (reg_write && cur.state == HST_IDLE) begin
            case (reg_addr)
                `OFS_ADDR:   next.start_addr = reg_wdata[23:0];
                `OFS_CONFIG: begin
                    next.dummy = reg_wdata[`CFG_DUMMY_LSB +: 4];
                    next.skip  = reg_wdata[`CFG_SKIP_BIT];
                    next.mode  = reg_wdata[`CFG_MODE_LSB +: 8];
                end
                `OFS_LENGTH: next.length = reg_wdata[15:0];
                `OFS_CONTROL: begin
                    if (reg_wdata[`CTRL_START_BIT]) begin
                        // Skip flag: device already in continuous read
                        next.state = cur.skip ? HST_ADDR : HST_CMD;
                        next.ph    = 2'h0;
                        next.cnt   = 16'h0;
                        next.cs_n  = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Byte halves: rising at phase 1, falling at phase 3
        if (sampling && cur.ph == 2'h1)
            next.rise = io_s;
        if (sampling && cur.ph == 2'h3) begin
            next.data    = {cur.rise, io_s};
            next.overrun = next.overrun | next.ready;
            next.ready   = 1'b1;
        end

        case (cur.state)
            HST_CMD: begin
                if (np == 2'h1) begin
                    next.io_out = {3'h0, cmd_shift[7]};
                    next.io_oe  = 4'h1;
                end
            end
            HST_ADDR: begin
                if (np[0]) begin
                    next.io_out = addr_shift[23:20];
                    next.io_oe  = 4'hf;
                end
            end
            HST_DUMMY: begin
                if (cur.cnt == 16'h0 && np == 2'h1) begin
                    next.io_out = cur.mode[7:4];
                    next.io_oe  = 4'hf;
                end
                if (cur.cnt == 16'h0 && np == 2'h3) begin
                    next.io_out = cur.mode[3:0];
                    next.io_oe  = (dummy_clocks(cur.dummy) > 4'h1) ? 4'hf : 4'h0;
                end
                if (cur.cnt != 16'h0)
                    next.io_oe = 4'h0;
            end
            HST_DATA: next.io_oe = 4'h0;
            HST_TAIL: next.io_oe = 4'h0;
            default:  next.io_oe = 4'h0;
        endcase

        // Link clock runs only in clocked phases; tail keeps it low
        next.sck = np[1] && (cur.state == HST_CMD || cur.state == HST_ADDR
                   || cur.state == HST_DUMMY || cur.state == HST_DATA);

        if (cur.ph == 2'h3) begin
            next.cnt = cur.cnt + 16'h1;
            case (cur.state)
                HST_CMD: if (cur.cnt[3:0] == `CMD_LAST) begin
                    next.state = HST_ADDR;
                    next.cnt   = 16'h0;
                end
                HST_ADDR: if (cur.cnt[3:0] == `ADDR_LAST) begin
                    next.state = HST_DUMMY;
                    next.cnt   = 16'h0;
                end
                HST_DUMMY: if (cur.cnt[3:0] == dummy_clocks(cur.dummy) - 4'h1) begin
                    next.state = HST_DATA;
                    next.cnt   = 16'h0;
                end
                HST_DATA: if (cur.cnt == last_byte) begin
                    next.state = HST_TAIL;
                    next.cnt   = 16'h0;
                end
                HST_TAIL: begin
                    next.state = HST_IDLE;
                    next.cs_n  = 1'b1;
                    next.done  = 1'b1;
                end
                default: next.cnt = 16'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur            <= '0;
            cur.state      <= HST_IDLE;
            cur.start_addr <= `RST_ADDR;
            cur.dummy      <= `RST_DUMMY;
            cur.mode       <= `RST_MODE;
            cur.length     <= `RST_LENGTH;
            cur.cs_n       <= 1'b1;
        end else begin
            cur <= next;
        end
    end

    assign reg_rdata        = cur.rdata;
    assign link.cs_n        = cur.cs_n;
    assign link.sck         = cur.sck;
    assign link.host_io_out = cur.io_out;
    assign link.host_io_oe  = cur.io_oe;

endmodule : qdr_host_end

`default_nettype wire

/* File: testbench/quad_io_dtr_read_sva.sv */
// Link checks of the quad double-rate read
`timescale 1ns/1ps
`default_nettype none

module quad_io_dtr_read_sva (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Link
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic [3:0] host_io_out,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_out,
    input wire logic [3:0] dev_io_oe,
    input wire logic [3:0] io
);
    logic       sck_q;
    logic [7:0] rises;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Rising link edges since chip enable fell
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        sck_q <= sck;
        if (rst || cs_n) rises <= 8'h00;
        else if (sck && !sck_q && rises != 8'hff) rises <= rises + 8'h01;
    end

    a_idle_released: assert property (cs_n |-> dev_io_oe == 4'h0)
        else $error("device drives while deselected");
    a_no_contention: assert property ((host_io_oe & dev_io_oe) == 4'h0)
        else $error("both ends drive a line");
    a_oe_uniform: assert property (dev_io_oe == 4'h0 || dev_io_oe == 4'hf)
        else $error("device drives only some lines");
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock high while deselected");
    a_sck_half_period: assert property ($rose(sck) |-> sck [*2] ##1 !sck)
        else $error("link clock high phase wrong");
    // Skip-mode frame still needs three address and one dummy clock
    a_data_after_dummy: assert property (dev_io_oe != 4'h0 |-> rises >= 8'h04)
        else $error("device drives before dummy phase ends");
    a_io_follows_dev: assert property (dev_io_oe == 4'hf |-> io == dev_io_out)
        else $error("lines do not carry device data");
    a_drive_on_rise: assert property ($rose(dev_io_oe[0]) |-> sck)
        else $error("device starts driving on a falling edge");
endmodule : quad_io_dtr_read_sva

`default_nettype wire

/* File: testbench/quad_io_dtr_read_tb_top.sv */
// Bench of the quad double-rate read with both ends facing each other
`timescale 1ns/1ps
`default_nettype none
`include "qdr_read_regs.svh"

module quad_io_dtr_read_tb_top;
    logic        clk_sys;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic        write_in_progress;
    logic        quad_lines_enable_bit;
    logic [3:0]  read_dummy_setting;
    logic [23:0] array_addr;
    logic [7:0]  array_data;
    logic        continuous_read_mode;
    logic [31:0] rnd;
    logic [7:0]  cmd_cap;
    logic [3:0]  cmd_cnt;
    logic        dev_drove;
    logic        cont_exp;
    int          error_cnt;
    int          comparisons;
    int          cyc;
    int          fall_drv;

    spi_quad_if lk ();
    qdr_host_end i_qdr_host_end (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .link(lk));
    qdr_flash_end i_qdr_flash_end (.link(lk), .rst(rst), .write_in_progress(write_in_progress),
        .quad_lines_enable_bit(quad_lines_enable_bit), .read_dummy_setting(read_dummy_setting),
        .array_addr(array_addr), .array_data(array_data),
        .continuous_read_mode(continuous_read_mode));
    quad_io_dtr_read_sva i_quad_io_dtr_read_sva (.clk_sys(clk_sys), .rst(rst), .cs_n(lk.cs_n),
        .sck(lk.sck), .host_io_out(lk.host_io_out), .host_io_oe(lk.host_io_oe),
        .dev_io_out(lk.dev_io_out), .dev_io_oe(lk.dev_io_oe), .io(lk.io));

    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
    endfunction : mem

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    assign array_data = mem(array_addr);

    // ----------------------------------------
    // Wire monitors
    // ----------------------------------------
    always @(posedge lk.sck or posedge lk.cs_n) begin
        if (lk.cs_n) begin
            cmd_cnt <= 4'h0;
        end else if (cmd_cnt < 4'h8) begin
            cmd_cap <= {cmd_cap[6:0], lk.io[0]};
            cmd_cnt <= cmd_cnt + 4'h1;
        end
    end

    always @(negedge lk.sck) begin
        if (lk.host_io_oe != 4'h0) fall_drv <= fall_drv + 1;
    end

    always @(posedge clk_sys) begin
        if (lk.dev_io_oe != 4'h0) dev_drove <= 1'b1;
        cyc <= cyc + 1;
        // Longest run is well under half this
        if (cyc == 40000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Leaves the strobe up so writes can follow back to back
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
    endtask : wr

    // ----------------------------------------
    // One read frame, status and data polled every cycle
    // ----------------------------------------
    task automatic frame(input logic [23:0] a, input logic [15:0] n, input logic [3:0] dum,
                         input logic [7:0] mode, input logic live);
        logic [23:0] ea;
        logic        got;
        logic        fin;
        logic        pend;
        int          k;
        int          cnt;
        ea = a;
        got = 1'b0;
        fin = 1'b0;
        pend = 1'b0;
        cnt = 0;
        dev_drove = 1'b0;
        fall_drv = 0;
        read_dummy_setting <= dum;
        wr(`OFS_ADDR, {8'h00, a});
        wr(`OFS_CONFIG, {16'h0, mode, 3'h0, cont_exp, dum});
        wr(`OFS_LENGTH, {16'h0, n});
        wr(`OFS_CONTROL, 32'h1);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        reg_addr  <= `OFS_CONTROL;
        for (k = 0; k < 2000 && !fin; k++) begin
            @(posedge clk_sys);
            #1;
            if (got) begin
                check("data", {24'h0, live ? mem(ea) : 8'hff}, reg_rdata);
                ea = (ea == `ARRAY_TOP_ADDR) ? 24'h0 : ea + 24'h1;
                cnt++;
                got = 1'b0;
                if (!pend) reg_addr <= `OFS_CONTROL;
            end else begin
                check("overrun", 32'h0, {31'h0, reg_rdata[`STAT_OVERRUN_BIT]});
                if (reg_rdata[`STAT_READY_BIT]) got = 1'b1;
                if (reg_rdata[`STAT_READY_BIT]) reg_addr <= `OFS_DATA;
                pend = pend | reg_rdata[`STAT_DONE_BIT];
            end
            fin = pend && !got;
        end
        reg_read <= 1'b0;
        check("frame end", 32'h1, {31'h0, fin});
        check("bytes", (n == 16'h0) ? 1 : n, cnt);
        check("driven", {31'h0, live}, {31'h0, dev_drove});
        if (!cont_exp) check("command", {24'h0, `CMD_QUAD_DOUBLE_RATE_READ}, {24'h0, cmd_cap});
        check("host drive", (cont_exp ? 3 : 11) + (dum != 4'h1), fall_drv);
        if (live) cont_exp = (mode[7:4] == `MODE_CONT_NIBBLE);
        check("continuous", {31'h0, cont_exp}, {31'h0, continuous_read_mode});
    endtask : frame

    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        write_in_progress = 1'b0;
        quad_lines_enable_bit = 1'b1;
        read_dummy_setting = 4'h0;
        dev_drove = 1'b0;
        cont_exp = 1'b0;
        rnd = 32'h3;
        error_cnt = 0;
        comparisons = 0;
        cyc = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= 8'h40;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        check("unmapped", 32'h0, reg_rdata);
        frame(24'h7ffffe, 16'h4, 4'h0, 8'hff, 1'b1);
        for (int i = 0; i < 12; i++) begin
            rnd = xs(rnd);
            frame({1'b0, rnd[22:0]}, {13'h0, rnd[26:24]} + 16'h1, i[3:0] % 4'h9, rnd[31:24], 1'b1);
        end
        frame(24'h000010, 16'h3, 4'h1, 8'ha5, 1'b1);
        frame(24'h123456, 16'h3, 4'h0, 8'ha0, 1'b1);
        frame(24'h7fffff, 16'h2, 4'h2, 8'h35, 1'b1);
        write_in_progress <= 1'b1;
        frame(24'h000100, 16'h0, 4'h0, 8'ha5, 1'b0);
        write_in_progress <= 1'b0;
        quad_lines_enable_bit <= 1'b0;
        frame(24'h000200, 16'h2, 4'h0, 8'ha5, 1'b0);
        quad_lines_enable_bit <= 1'b1;
        frame(24'h000300, 16'h2, 4'h0, 8'hff, 1'b1);
        close_out();
    end
endmodule : quad_io_dtr_read_tb_top

`default_nettype wire
